// [rtl/olc_pkg.sv]
`default_nettype none
package olc_pkg;

  // ==========================================================
  // Sizes and OTP layout
  localparam int OTP_AW = 7;
  localparam int OTP_DW = 8;
  localparam int IDX_W = 4;
  localparam int GPIO_W = 4;
  localparam int SPI_W = 5;
  localparam int SUSP_IND_PIN = 2;
  localparam int INT_WAKE_PIN = 3;
  localparam logic [IDX_W-1:0] CFG_BYTES = 4'h9;
  localparam logic [OTP_AW-1:0] OTP_CFG_BASE = 7'h00;

  // Byte offsets inside the configuration area
  localparam logic [IDX_W-1:0] OFS_CHIP = 4'h0;
  localparam logic [IDX_W-1:0] OFS_VID_LO = 4'h1;
  localparam logic [IDX_W-1:0] OFS_VID_HI = 4'h2;
  localparam logic [IDX_W-1:0] OFS_PID_LO = 4'h3;
  localparam logic [IDX_W-1:0] OFS_PID_HI = 4'h4;
  localparam logic [IDX_W-1:0] OFS_FLAGS = 4'h5;
  localparam logic [IDX_W-1:0] OFS_MAXPWR = 4'h6;
  localparam logic [IDX_W-1:0] OFS_I2C = 4'h7;
  localparam logic [IDX_W-1:0] OFS_PINS = 4'h8;

  // Flag byte bit positions
  localparam int FB_SELF = 0;
  localparam int FB_WAKE = 1;
  localparam int FB_SERIAL = 2;
  localparam int FB_SUSP_EN = 3;
  localparam int FB_SUSP_POL = 4;
  localparam int FB_OD = 5;
  localparam int FB_CHG_DIS = 6;
  localparam int FB_CHG_POL = 7;

  // Pin byte bit positions
  localparam int PB_SPI_EN = 0;
  localparam int PB_SPI_ACT = 1;
  localparam int PB_GPIO_SUSP = 3;
  localparam int PB_INT_FALL = 5;

  // ==========================================================
  // Fixed values and factory defaults
  localparam logic [15:0] USB_VER = 16'h0200;
  localparam logic [7:0] MAXPWR_LIMIT = 8'hFA; // 500 mA in 2 mA units
  localparam logic [7:0] MAXPWR_DEF = 8'h32; // 100 mA
  localparam logic [6:0] I2C_ADDR_DEF = 7'h40;
  localparam logic [15:0] VID_DEF = 16'hC0DE; // Arbitrary value
  localparam logic [15:0] PID_DEF = 16'h0A01; // Arbitrary value
  localparam logic [7:0] CHIP_TYPE_DEF = 8'h5A; // Arbitrary value
  localparam logic [1:0] SPI_ACT_HIGH = 2'h1;
  localparam logic [1:0] SPI_ACT_LOW = 2'h2;

  typedef enum logic [1:0] {
    SUSP_KEEP = 2'b00,
    SUSP_TRI = 2'b01,
    SUSP_HIGH = 2'b10,
    SUSP_LOW = 2'b11
  } olc_susp_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_READ = 3'b001,
    S_CAPT = 3'b010,
    S_APPLY = 3'b011,
    S_LOAD = 3'b100,
    S_DONE = 3'b101
  } olc_state_e;

  typedef struct packed {
    logic self_pwr;
    logic remote_wake;
    logic serial_en;
    logic susp_out_en;
    logic susp_pol_low;
    logic gpio_od;
    logic chg_dis;
    logic chg_pol_low;
    logic [7:0] max_pwr;
    logic [6:0] i2c_addr;
    logic spi_ctl_en;
    logic [1:0] spi_act;
    olc_susp_e gpio_susp;
    logic int_fall;
  } olc_cfg_s;

  localparam olc_cfg_s CFG_DEF = '{
    self_pwr: 1'b0, remote_wake: 1'b1, serial_en: 1'b0,
    susp_out_en: 1'b1, susp_pol_low: 1'b0, gpio_od: 1'b0,
    chg_dis: 1'b0, chg_pol_low: 1'b0, max_pwr: MAXPWR_DEF,
    i2c_addr: I2C_ADDR_DEF, spi_ctl_en: 1'b0, spi_act: 2'h0,
    gpio_susp: SUSP_TRI, int_fall: 1'b0};

  typedef struct packed {
    logic [15:0] vid;
    logic [15:0] pid;
    logic [15:0] usb_ver;
    logic self_pwr;
    logic [7:0] max_pwr;
    logic remote_wake;
    logic serial_en;
  } olc_desc_s;

endpackage
`default_nettype wire

// [rtl/olc_shadow_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module olc_shadow_mem #(
  parameter int DW = 8,
  parameter int AW = 4
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  // Array has no reset; only scanned bytes are ever read back
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

  // Last write kept aside; the apply pass reads it back long after it was written
  logic chk_vld_r;
  logic [AW-1:0] chk_waddr_r;
  logic [DW-1:0] chk_wdata_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      chk_vld_r <= 1'b0;
      chk_waddr_r <= '0;
      chk_wdata_r <= '0;
    end else if (we_i) begin
      chk_vld_r <= 1'b1;
      chk_waddr_r <= waddr_i;
      chk_wdata_r <= wdata_i;
    end
  end

  sequence s_rd_last_wr;
    chk_vld_r && re_i && !we_i && raddr_i == chk_waddr_r;
  endsequence

  a_shadow_rdback: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_rd_last_wr |=> rdata_o == $past(chk_wdata_r))
    else $error("shadow byte read back differs from scanned byte");
endmodule
`default_nettype wire

// [rtl/olc_pin_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
module olc_pin_ctl
  import olc_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic suspend_i,
  input wire olc_susp_e mode_i,
  input wire logic od_i,
  input wire logic [W-1:0] exempt_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_o
);
  logic [W-1:0] held_o_r;
  logic [W-1:0] held_e_r;
  logic [W-1:0] o_nxt;
  logic [W-1:0] e_nxt;

  // Track the pin state while awake so "no change" freezes it on suspend
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      held_o_r <= '0;
      held_e_r <= '0;
    end else if (!suspend_i) begin
      held_o_r <= out_i;
      held_e_r <= oe_i;
    end
  end

  // Suspend override per pin, then open-drain conversion
  always_comb begin
    for (int i = 0; i < W; i++) begin
      o_nxt[i] = out_i[i];
      e_nxt[i] = oe_i[i];
      if (suspend_i && !exempt_i[i]) begin
        unique case (mode_i)
          SUSP_KEEP: begin
            o_nxt[i] = held_o_r[i];
            e_nxt[i] = held_e_r[i];
          end
          SUSP_TRI: e_nxt[i] = 1'b0;
          SUSP_HIGH: begin
            o_nxt[i] = 1'b1;
            e_nxt[i] = 1'b1;
          end
          SUSP_LOW: begin
            o_nxt[i] = 1'b0;
            e_nxt[i] = 1'b1;
          end
        endcase
      end
      // Open drain only ever pulls low; a high becomes release
      if (od_i) begin
        e_nxt[i] = e_nxt[i] & ~o_nxt[i];
        o_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_o <= o_nxt;
      pin_oe_o <= e_nxt;
    end
  end

  a_pin_od_nohigh: assert property (@(posedge core_clk_i) disable iff (reset_i)
    od_i |=> (pin_o & pin_oe_o) == '0)
    else $error("open-drain pin driven high");

  a_pin_susp_tri: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (suspend_i && mode_i == SUSP_TRI) |=> (pin_oe_o & ~$past(exempt_i)) == '0)
    else $error("pin still driven in tri-state suspend");
endmodule
`default_nettype wire

// [rtl/olc_loader.sv]
// Operation
// - Scan OTP and load descriptors after power-on reset and after each bus reset.
// - Chip-type field is read-only and never changes.
// - Vendor code is a 16-bit field placed in the device descriptor.
// - Product code is a 16-bit field placed in the device descriptor.
// - USB version reads 0200h; full-speed fallback leaves it unchanged.
// - Power source selects bus or self powered; bus powered by default.
// - Max current 0 to 500 mA, default 100 mA, zero when self powered.
// - Remote wake-up support bit, enabled by default.
// - Serial-number string enable bit, disabled by default.
// - Suspend indicator pin shows USB suspend when enabled, enabled by default.
// - Suspend indicator polarity selectable, active high by default.
// - I2C target address 00h to 7Fh, default 40h.
// - SPI pins tri-state on suspend unless pin control holds or drives them.
// - GPIO suspend action: no change, tri-state, high or low; default tri-state.
// - GPIO pins push-pull by default, open drain when selected.
// - Charger-detect function can be disabled; enabled by default.
// - Charger-detect output polarity selectable, active high by default.
// - Interrupt or wake input triggers on the configured edge, rising by default.
// - Charger-detect active only for a charging port seen during suspend.
`timescale 1ns/1ps
`default_nettype none
module olc_loader
  import olc_pkg::*;
#(
  parameter logic [7:0] CHIP_TYPE_ID = CHIP_TYPE_DEF // Arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic usb_bus_reset_i,
  output logic otp_rd_o,
  output logic [OTP_AW-1:0] otp_addr_o,
  input wire logic [OTP_DW-1:0] otp_data_i,
  output olc_desc_s desc_o,
  output logic desc_valid_o,
  output logic scan_busy_o,
  output logic [7:0] chip_type_o,
  input wire logic host_hs_i,
  output logic hs_mode_o,
  output logic [6:0] i2c_addr_o,
  input wire logic suspend_i,
  input wire logic dcp_detect_i,
  output logic charger_detect_out_o,
  input wire logic [GPIO_W-1:0] gpio_out_i,
  input wire logic [GPIO_W-1:0] gpio_oe_i,
  input wire logic [GPIO_W-1:0] gpio_in_i,
  output logic [GPIO_W-1:0] gpio_o,
  output logic [GPIO_W-1:0] gpio_oe_o,
  input wire logic [SPI_W-1:0] spi_out_i,
  input wire logic [SPI_W-1:0] spi_oe_i,
  output logic [SPI_W-1:0] spi_o,
  output logic [SPI_W-1:0] spi_oe_o,
  input wire logic int_func_en_i,
  output logic int_wake_evt_o
);

  // ==========================================================
  // Scan sequencer
  olc_state_e st_r;
  olc_state_e st_nxt;
  logic [IDX_W-1:0] idx_r;
  logic [IDX_W-1:0] idx_nxt;
  logic last_w;
  logic done_w;
  logic sh_we;
  logic sh_re;
  logic [OTP_DW-1:0] sh_rdata;

  assign last_w = (idx_r == CFG_BYTES - 4'h1);
  assign done_w = (st_r == S_DONE);
  assign sh_we = (st_r == S_CAPT);
  assign sh_re = (st_r == S_APPLY);

  // Bus reset restarts the scan from any state and wins over progress
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    if (usb_bus_reset_i) begin
      st_nxt = S_READ;
      idx_nxt = '0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          st_nxt = S_READ;
          idx_nxt = '0;
        end
        S_READ: st_nxt = S_CAPT;
        S_CAPT: begin
          st_nxt = last_w ? S_APPLY : S_READ;
          idx_nxt = last_w ? '0 : idx_r + 4'h1;
        end
        S_APPLY: st_nxt = S_LOAD;
        S_LOAD: begin
          st_nxt = last_w ? S_DONE : S_APPLY;
          idx_nxt = last_w ? '0 : idx_r + 4'h1;
        end
        S_DONE: st_nxt = S_DONE;
        default: begin
          st_nxt = S_IDLE;
          idx_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= S_IDLE;
      idx_r <= '0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
    end
  end

  // OTP read strobe; data is taken on the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      otp_rd_o <= 1'b0;
      otp_addr_o <= '0;
    end else begin
      otp_rd_o <= (st_nxt == S_READ);
      otp_addr_o <= OTP_CFG_BASE + {3'h0, idx_nxt};
    end
  end

  // Scanned bytes are staged first so a half-read OTP never leaks out
  olc_shadow_mem #(
    .DW(OTP_DW),
    .AW(IDX_W)
  ) u_shadow (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .we_i(sh_we),
    .waddr_i(idx_r),
    .wdata_i(otp_data_i),
    .re_i(sh_re),
    .raddr_i(idx_r),
    .rdata_o(sh_rdata)
  );

  // ==========================================================
  // Live configuration decode
  olc_cfg_s live_r;
  olc_cfg_s eff;
  logic [15:0] vid_r;
  logic [15:0] pid_r;
  logic [7:0] pwr_clamp;

  // Out-of-range current codes saturate at the bus limit
  assign pwr_clamp = (sh_rdata > MAXPWR_LIMIT) ? MAXPWR_LIMIT : sh_rdata;

  // Chip-type byte is scanned but never written anywhere
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      live_r <= CFG_DEF;
      vid_r <= VID_DEF;
      pid_r <= PID_DEF;
    end else if (st_r == S_LOAD) begin
      unique case (idx_r)
        OFS_VID_LO: vid_r[7:0] <= sh_rdata;
        OFS_VID_HI: vid_r[15:8] <= sh_rdata;
        OFS_PID_LO: pid_r[7:0] <= sh_rdata;
        OFS_PID_HI: pid_r[15:8] <= sh_rdata;
        OFS_FLAGS: begin
          live_r.self_pwr <= sh_rdata[FB_SELF];
          live_r.remote_wake <= sh_rdata[FB_WAKE];
          live_r.serial_en <= sh_rdata[FB_SERIAL];
          live_r.susp_out_en <= sh_rdata[FB_SUSP_EN];
          live_r.susp_pol_low <= sh_rdata[FB_SUSP_POL];
          live_r.gpio_od <= sh_rdata[FB_OD];
          live_r.chg_dis <= sh_rdata[FB_CHG_DIS];
          live_r.chg_pol_low <= sh_rdata[FB_CHG_POL];
        end
        OFS_MAXPWR: live_r.max_pwr <= pwr_clamp;
        OFS_I2C: live_r.i2c_addr <= sh_rdata[6:0];
        OFS_PINS: begin
          live_r.spi_ctl_en <= sh_rdata[PB_SPI_EN];
          live_r.spi_act <= sh_rdata[PB_SPI_ACT +: 2];
          live_r.gpio_susp <= olc_susp_e'(sh_rdata[PB_GPIO_SUSP +: 2]);
          live_r.int_fall <= sh_rdata[PB_INT_FALL];
        end
        default: ;
      endcase
    end
  end

  // Defaults stand until the whole area has been applied
  assign eff = done_w ? live_r : CFG_DEF;

  // ==========================================================
  // Descriptor and identity outputs
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      desc_o <= '{VID_DEF, PID_DEF, USB_VER, 1'b0, MAXPWR_DEF, 1'b1, 1'b0};
      desc_valid_o <= 1'b0;
      scan_busy_o <= 1'b1;
      chip_type_o <= CHIP_TYPE_ID;
      hs_mode_o <= 1'b0;
      i2c_addr_o <= I2C_ADDR_DEF;
    end else begin
      desc_o.vid <= done_w ? vid_r : VID_DEF;
      desc_o.pid <= done_w ? pid_r : PID_DEF;
      desc_o.usb_ver <= USB_VER;
      desc_o.self_pwr <= eff.self_pwr;
      desc_o.max_pwr <= eff.self_pwr ? 8'h00 : eff.max_pwr;
      desc_o.remote_wake <= eff.remote_wake;
      desc_o.serial_en <= eff.serial_en;
      desc_valid_o <= done_w;
      scan_busy_o <= !done_w;
      chip_type_o <= CHIP_TYPE_ID;
      hs_mode_o <= host_hs_i;
      i2c_addr_o <= eff.i2c_addr;
    end
  end

  // ==========================================================
  // Charger detect
  logic chg_on;

  // Only a charging port seen while suspended counts; an enumerating host never does
  assign chg_on = !eff.chg_dis && suspend_i && dcp_detect_i;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      charger_detect_out_o <= 1'b0;
    end else begin
      charger_detect_out_o <= chg_on ^ eff.chg_pol_low;
    end
  end

  // ==========================================================
  // GPIO and SPI pin behaviour
  logic [GPIO_W-1:0] g_out;
  logic [GPIO_W-1:0] g_oe;
  logic [GPIO_W-1:0] g_exempt;
  logic susp_ind;
  olc_susp_e spi_mode;

  // Suspend indicator is owned by the block and is not overridden on suspend
  assign susp_ind = suspend_i ^ eff.susp_pol_low;

  always_comb begin
    g_out = gpio_out_i;
    g_oe = gpio_oe_i;
    g_exempt = '0;
    if (eff.susp_out_en) begin
      g_out[SUSP_IND_PIN] = susp_ind;
      g_oe[SUSP_IND_PIN] = 1'b1;
      g_exempt[SUSP_IND_PIN] = 1'b1;
    end
  end

  // SPI: tri-state unless pin control picks hold, high or low
  always_comb begin
    if (!eff.spi_ctl_en) begin
      spi_mode = SUSP_TRI;
    end else if (eff.spi_act == SPI_ACT_HIGH) begin
      spi_mode = SUSP_HIGH;
    end else if (eff.spi_act == SPI_ACT_LOW) begin
      spi_mode = SUSP_LOW;
    end else begin
      spi_mode = SUSP_KEEP;
    end
  end

  olc_pin_ctl #(
    .W(GPIO_W)
  ) u_gpio_pins (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .suspend_i(suspend_i),
    .mode_i(eff.gpio_susp),
    .od_i(eff.gpio_od),
    .exempt_i(g_exempt),
    .out_i(g_out),
    .oe_i(g_oe),
    .pin_o(gpio_o),
    .pin_oe_o(gpio_oe_o)
  );

  // SPI pins have no open-drain mode
  olc_pin_ctl #(
    .W(SPI_W)
  ) u_spi_pins (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .suspend_i(suspend_i),
    .mode_i(spi_mode),
    .od_i(1'b0),
    .exempt_i('0),
    .out_i(spi_out_i),
    .oe_i(spi_oe_i),
    .pin_o(spi_o),
    .pin_oe_o(spi_oe_o)
  );

  // ==========================================================
  // Interrupt or wake edge detect on interrupt_wake_pin
  logic wake_prev_r;
  logic wake_primed_r;
  logic wake_rise;
  logic wake_fall;

  assign wake_rise = gpio_in_i[INT_WAKE_PIN] && !wake_prev_r;
  assign wake_fall = !gpio_in_i[INT_WAKE_PIN] && wake_prev_r;

  // Primed flag stops a pin already high at reset release from firing
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_prev_r <= 1'b0;
      wake_primed_r <= 1'b0;
      int_wake_evt_o <= 1'b0;
    end else begin
      wake_prev_r <= gpio_in_i[INT_WAKE_PIN];
      wake_primed_r <= 1'b1;
      int_wake_evt_o <= wake_primed_r && int_func_en_i &&
                        (eff.int_fall ? wake_fall : wake_rise);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_rescan;
    (otp_rd_o && otp_addr_o == OTP_CFG_BASE) ##1 !otp_rd_o
      ##1 (otp_rd_o && otp_addr_o == OTP_CFG_BASE + 7'h01);
  endsequence

  a_bus_rescan: assert property ($fell(usb_bus_reset_i) |-> s_rescan)
    else $error("bus reset did not restart the OTP scan");

  a_scan_bounded: assert property (disable iff (reset_i || usb_bus_reset_i)
    (otp_rd_o && otp_addr_o == OTP_CFG_BASE) |-> ##[1:60] desc_valid_o)
    else $error("OTP scan did not finish in time");

  a_chip_fixed: assert property (##1 chip_type_o == $past(chip_type_o))
    else $error("chip type changed");

  a_usb_ver_fixed: assert property (desc_o.usb_ver == USB_VER &&
    (hs_mode_o == $past(host_hs_i) || $past(reset_i)))
    else $error("USB version altered or speed not followed");

  a_self_zero: assert property (desc_o.self_pwr |-> desc_o.max_pwr == 8'h00)
    else $error("self powered but max current nonzero");

  a_pwr_range: assert property (desc_o.max_pwr <= MAXPWR_LIMIT)
    else $error("max current above limit");

  a_defaults_hold: assert property (!desc_valid_o |-> desc_o.vid == VID_DEF &&
    desc_o.pid == PID_DEF && i2c_addr_o == I2C_ADDR_DEF)
    else $error("non-default value shown before scan done");

  a_chg_idle: assert property (!$past(suspend_i) |->
    charger_detect_out_o == $past(eff.chg_pol_low))
    else $error("charger detect active outside suspend");

  a_susp_ind: assert property ($past(eff.susp_out_en && !eff.gpio_od && !reset_i) |->
    gpio_o[SUSP_IND_PIN] == $past(susp_ind) && gpio_oe_o[SUSP_IND_PIN])
    else $error("suspend indicator pin wrong");

  a_wake_edge: assert property ((wake_primed_r && int_func_en_i &&
    (eff.int_fall ? wake_fall : wake_rise)) |=> int_wake_evt_o)
    else $error("configured edge missed");

  a_spi_tri: assert property ((suspend_i && !eff.spi_ctl_en) |=> spi_oe_o == '0)
    else $error("SPI pins driven in default suspend");

endmodule
`default_nettype wire

// [verification/olc_otp_model.sv]
`timescale 1ns/1ps
`default_nettype none
module olc_otp_model
  import olc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rd_i,
  input wire logic [OTP_AW-1:0] addr_i,
  input wire logic [8:0][OTP_DW-1:0] image_i,
  output logic [OTP_DW-1:0] data_o
);
  // ==========================================================
  // Read port
  // One-cycle latency; between reads the line toggles so stale data never looks valid
  always_ff @(posedge core_clk_i) begin
    if (rd_i) begin
      data_o <= (addr_i < 7'h09) ? image_i[addr_i[3:0]] : 8'hFF;
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule
`default_nettype wire

// [verification/otp_config_loader_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module otp_config_loader_tb;
  import olc_pkg::*;

  // ==========================================================
  // Signals
  logic core_clk_i, reset_i, usb_bus_reset_i, otp_rd_o, desc_valid_o, scan_busy_o;
  logic host_hs_i, hs_mode_o, suspend_i, dcp_detect_i, charger_detect_out_o;
  logic int_func_en_i, int_wake_evt_o;
  logic [OTP_AW-1:0] otp_addr_o;
  logic [OTP_DW-1:0] otp_data_i;
  logic [7:0] chip_type_o;
  logic [6:0] i2c_addr_o;
  logic [GPIO_W-1:0] gpio_out_i, gpio_oe_i, gpio_in_i, gpio_o, gpio_oe_o;
  logic [SPI_W-1:0] spi_out_i, spi_oe_i, spi_o, spi_oe_o;
  olc_desc_s desc_o;
  logic [8:0][7:0] image;
  logic [8:0][7:0] rows [4];
  int n_errors = 0;
  int tests_run = 0;
  int n;

  olc_loader olc_loader_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .usb_bus_reset_i(usb_bus_reset_i), .otp_rd_o(otp_rd_o), .otp_addr_o(otp_addr_o),
    .otp_data_i(otp_data_i), .desc_o(desc_o), .desc_valid_o(desc_valid_o),
    .scan_busy_o(scan_busy_o), .chip_type_o(chip_type_o), .host_hs_i(host_hs_i),
    .hs_mode_o(hs_mode_o), .i2c_addr_o(i2c_addr_o), .suspend_i(suspend_i),
    .dcp_detect_i(dcp_detect_i), .charger_detect_out_o(charger_detect_out_o),
    .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .gpio_in_i(gpio_in_i),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o), .spi_out_i(spi_out_i), .spi_oe_i(spi_oe_i),
    .spi_o(spi_o), .spi_oe_o(spi_oe_o), .int_func_en_i(int_func_en_i),
    .int_wake_evt_o(int_wake_evt_o));

  olc_otp_model olc_otp_model_inst (.core_clk_i(core_clk_i), .rd_i(otp_rd_o),
    .addr_i(otp_addr_o), .image_i(image), .data_o(otp_data_i));

  // ==========================================================
  // Clock and helpers
  initial core_clk_i = 1'b0;
  always #25 core_clk_i = ~core_clk_i;

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask

  // Bounded wait so a scan that never ends shows as a mismatch, not a hang
  task automatic wait_valid(output int cnt);
    cnt = 0;
    while (desc_valid_o !== 1'b1 && cnt < 200) begin
      @(negedge core_clk_i);
      cnt++;
    end
  endtask

  // Descriptor as the stored bytes should present it
  function automatic olc_desc_s exp_desc(input logic [8:0][7:0] im);
    olc_desc_s d;
    d.vid = {im[2], im[1]};
    d.pid = {im[4], im[3]};
    d.usb_ver = USB_VER;
    d.self_pwr = im[5][FB_SELF];
    d.max_pwr = im[5][FB_SELF] ? 8'h00 : (im[6] > MAXPWR_LIMIT ? MAXPWR_LIMIT : im[6]);
    d.remote_wake = im[5][FB_WAKE];
    d.serial_en = im[5][FB_SERIAL];
    return d;
  endfunction

  // Suspend, charger, open-drain and wake behaviour for one loaded image
  task automatic pins(input logic [8:0][7:0] im);
    logic [1:0] gm;
    gm = im[8][4:3];
    suspend_i = 1'b1;
    dcp_detect_i = 1'b1;
    cyc(2);
    check(charger_detect_out_o, !im[5][FB_CHG_DIS] ^ im[5][FB_CHG_POL]);
    check(spi_oe_o, (im[8][PB_SPI_EN] && ^im[8][2:1]) ? 5'h1F : 5'h00);
    check(spi_o, (im[8][PB_SPI_EN] && im[8][2:1] == SPI_ACT_HIGH) ? 5'h1F : 5'h00);
    check(gpio_oe_o[0], gm == 2'b01 ? 1'b0 : (gm == 2'b10 ? !im[5][FB_OD] : 1'b1));
    if (im[5][FB_SUSP_EN]) check({gpio_o[2], gpio_oe_o[2]}, {!im[5][FB_SUSP_POL], 1'b1});
    dcp_detect_i = 1'b0;
    cyc(2);
    check(charger_detect_out_o, im[5][FB_CHG_POL]);
    suspend_i = 1'b0;
    dcp_detect_i = 1'b1;
    cyc(2);
    check(charger_detect_out_o, im[5][FB_CHG_POL]);
    check({gpio_o[0], gpio_oe_o[0]}, im[5][FB_OD] ? 2'b00 : 2'b11);
    dcp_detect_i = 1'b0;
    // The event pulse stands for exactly the cycle after the edge it reports
    gpio_in_i = 4'h8;
    cyc(1);
    check(int_wake_evt_o, !im[8][PB_INT_FALL]);
    gpio_in_i = 4'h0;
    cyc(1);
    check(int_wake_evt_o, im[8][PB_INT_FALL]);
    cyc(2);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rows[0] = {8'h08, 8'h40, 8'h32, 8'h0A, 8'h56, 8'h78, 8'h12, 8'h34, 8'hA5};
    rows[1] = {8'h33, 8'h7F, 8'h64, 8'hF5, 8'hBE, 8'hEF, 8'hFE, 8'hED, 8'hA5};
    rows[2] = {8'h1D, 8'h00, 8'hFF, 8'h18, 8'h00, 8'h01, 8'h00, 8'h02, 8'hA5};
    rows[3] = {8'h01, 8'h11, 8'hFA, 8'h02, 8'h20, 8'h01, 8'h10, 8'h01, 8'hA5};
    reset_i = 1'b1;
    usb_bus_reset_i = 1'b0;
    host_hs_i = 1'b0;
    suspend_i = 1'b0;
    dcp_detect_i = 1'b0;
    gpio_out_i = 4'h1;
    gpio_oe_i = 4'h1;
    gpio_in_i = 4'h0;
    spi_out_i = 5'h00;
    spi_oe_i = 5'h00;
    int_func_en_i = 1'b1;
    image = rows[0];
    cyc(3);
    check(desc_o, olc_desc_s'{VID_DEF, PID_DEF, USB_VER, 1'b0, MAXPWR_DEF, 1'b1, 1'b0});
    check({desc_valid_o, scan_busy_o, i2c_addr_o}, {2'b01, I2C_ADDR_DEF});
    reset_i = 1'b0;
    wait_valid(n);
    check(n, 38);
    check(desc_o, exp_desc(image));
    // Each row is rescanned through a bus reset, then checked end to end
    for (int i = 0; i < 4; i++) begin
      image = rows[i];
      usb_bus_reset_i = 1'b1;
      cyc(1);
      usb_bus_reset_i = 1'b0;
      cyc(2);
      check({desc_valid_o, desc_o.vid}, {1'b0, VID_DEF});
      check({otp_rd_o, otp_addr_o, scan_busy_o}, {1'b1, OTP_CFG_BASE + 7'h01, 1'b1});
      wait_valid(n);
      check(desc_o, exp_desc(image));
      check(i2c_addr_o, image[7][6:0]);
      check(chip_type_o, CHIP_TYPE_DEF);
      pins(image);
    end
    // Full-speed fallback keeps the reported version
    host_hs_i = 1'b1;
    cyc(2);
    check({hs_mode_o, desc_o.usb_ver}, {1'b1, USB_VER});
    host_hs_i = 1'b0;
    cyc(2);
    check({hs_mode_o, desc_o.usb_ver}, {1'b0, USB_VER});
    // Power-on reset in the middle of a rescan
    usb_bus_reset_i = 1'b1;
    cyc(1);
    usb_bus_reset_i = 1'b0;
    cyc(8);
    reset_i = 1'b1;
    cyc(2);
    check({desc_valid_o, scan_busy_o, otp_rd_o}, 3'b010);
    reset_i = 1'b0;
    wait_valid(n);
    check(n, 38);
    check(desc_o, exp_desc(image));
    stop_test();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
